//--- idl_pkg.sv
// package: register map, reset values and widths of the isolated digital i/o port
package idl_pkg;
  localparam int idl_in_width = 8;
  localparam int idl_out_width = 7;
  localparam logic [11:0] idl_polarity_off = 12'h000;
  localparam logic [11:0] idl_output_off = 12'h004;
  localparam logic [11:0] idl_input_off = 12'h008;
  localparam logic [11:0] idl_latch_off = 12'h00c;
  localparam logic [11:0] idl_latch_clear_off = 12'h010;
  localparam logic [11:0] idl_irq_status_off = 12'h014;
  localparam logic [11:0] idl_irq_mask_off = 12'h018;
  localparam logic [7:0] idl_polarity_reset = 8'h00;
  localparam logic [6:0] idl_output_reset = 7'h00;
  localparam logic [7:0] idl_mask_reset = 8'h00;
  localparam logic [7:0] idl_status_reset = 8'h00;
  localparam logic [31:0] idl_rdata_reset = 32'h0000_0000;
endpackage : idl_pkg

//--- idl_input_qualify.sv
// per-channel polarity qualification and sticky latch of the isolated inputs
`timescale 1ns/100ps
`default_nettype none
module idl_input_qualify #(
  parameter int width = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [width-1:0] raw_in,
  input wire logic [width-1:0] polarity,
  input wire logic [width-1:0] clear_mask,
  output logic [width-1:0] asserted,
  output logic [width-1:0] latch,
  output logic [width-1:0] rise_event
);
  typedef struct packed {
    logic [width-1:0] asserted;
    logic [width-1:0] latch;
    logic [width-1:0] rise_event;
  } idl_qual_state_type;

  idl_qual_state_type state;
  idl_qual_state_type next_state;

  always_comb begin
    next_state = state;
    for (int n = 0; n < width; n++) begin
      // polarity 1: high is asserted; polarity 0: low is asserted
      next_state.asserted[n] = polarity[n] ? raw_in[n] : ~raw_in[n];
      next_state.rise_event[n] = next_state.asserted[n] & ~state.asserted[n];
      // set wins over clear so an edge in the clear cycle is kept
      if (next_state.rise_event[n]) begin
        next_state.latch[n] = 1'b1;
      end else if (clear_mask[n]) begin
        next_state.latch[n] = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign asserted = state.asserted;
  assign latch = state.latch;
  assign rise_event = state.rise_event;
endmodule // idl_input_qualify
`default_nettype wire

//--- idl_port.sv
// top of the isolated digital i/o port: apb registers, outputs, inputs, latches, interrupt
//
// How it works
// - an eight-bit polarity register has bit n choose the active sense of input channel n.
// - a channel whose polarity bit is zero counts as asserted while its input is low.
// - a channel whose polarity bit is one counts as asserted while its input is high.
// - reading the polarity register returns the stored eight-bit setting.
// - seven open-collector outputs follow bits zero to six of the written output value.
// - an output is off when its bit is zero and on when its bit is one.
// - the last written output value reads back unchanged.
// - a live input read returns each channel with its polarity applied, bit n for channel n.
// - one latch bit per input channel is reported as a byte, bit n for channel n.
// - the latch byte has its polarity applied: a bit sets when its channel becomes asserted.
// - writing ones to the latch clear register clears those latches; zero means cleared.
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module idl_port #(
  parameter int in_width = idl_pkg::idl_in_width,
  parameter int out_width = idl_pkg::idl_out_width
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [in_width-1:0] isolated_inputs,
  output logic [out_width-1:0] oc_out,
  output logic [out_width-1:0] oc_out_en,
  output logic irq
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [in_width-1:0] input_polarity_byte;
    logic [out_width-1:0] output_value_byte;
    logic [in_width-1:0] irq_status;
    logic [in_width-1:0] irq_mask;
    logic [31:0] rdata;
    logic slverr;
    logic irq;
  } idl_port_state_type;

  idl_port_state_type state;
  idl_port_state_type next_state;

  logic [in_width-1:0] asserted;
  logic [in_width-1:0] latch;
  logic [in_width-1:0] rise_event;
  logic [in_width-1:0] clear_mask;
  logic access;
  logic wr;

  // decode of the mapped offsets, used only by the error flag
  function automatic logic idl_is_mapped(input logic [11:0] a);
    idl_is_mapped = (a == idl_pkg::idl_polarity_off) || (a == idl_pkg::idl_output_off) ||
                    (a == idl_pkg::idl_input_off) || (a == idl_pkg::idl_latch_off) ||
                    (a == idl_pkg::idl_latch_clear_off) || (a == idl_pkg::idl_irq_status_off) ||
                    (a == idl_pkg::idl_irq_mask_off);
  endfunction

  // ==========================================================
  // input qualification and latches
  idl_input_qualify #(
    .width(in_width)
  ) u_qualify (
    .pclk(pclk),
    .presetn(presetn),
    .raw_in(isolated_inputs),
    .polarity(state.input_polarity_byte),
    .clear_mask(clear_mask),
    .asserted(asserted),
    .latch(latch),
    .rise_event(rise_event)
  );

  // ==========================================================
  // apb access, zero wait states
  assign access = psel & penable;
  assign wr = access & pwrite & pstrb[0];
  assign pready = 1'b1;

  always_comb begin
    clear_mask = '0;
    if (wr && paddr == idl_pkg::idl_latch_clear_off) begin
      clear_mask = pwdata[in_width-1:0];
    end
  end

  always_comb begin
    next_state = state;
    next_state.slverr = 1'b0;
    if (wr) begin
      if (paddr == idl_pkg::idl_polarity_off) begin
        next_state.input_polarity_byte = pwdata[in_width-1:0];
      end else if (paddr == idl_pkg::idl_output_off) begin
        next_state.output_value_byte = pwdata[out_width-1:0];
      end else if (paddr == idl_pkg::idl_irq_mask_off) begin
        next_state.irq_mask = pwdata[in_width-1:0];
      end else if (paddr == idl_pkg::idl_irq_status_off) begin
        next_state.irq_status = state.irq_status & ~pwdata[in_width-1:0];
      end
    end
    // a rising channel in the clearing cycle stays pending
    next_state.irq_status = next_state.irq_status | rise_event;
    next_state.irq = |(next_state.irq_status & next_state.irq_mask);
    // read data is registered; rdata is taken at the edge ending the setup phase from this value
    next_state.rdata = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      if (paddr == idl_pkg::idl_polarity_off) begin
        next_state.rdata[in_width-1:0] = state.input_polarity_byte;
      end else if (paddr == idl_pkg::idl_output_off) begin
        next_state.rdata[out_width-1:0] = state.output_value_byte;
      end else if (paddr == idl_pkg::idl_input_off) begin
        next_state.rdata[in_width-1:0] = asserted;
      end else if (paddr == idl_pkg::idl_latch_off) begin
        next_state.rdata[in_width-1:0] = latch;
      end else if (paddr == idl_pkg::idl_irq_status_off) begin
        next_state.rdata[in_width-1:0] = state.irq_status;
      end else if (paddr == idl_pkg::idl_irq_mask_off) begin
        next_state.rdata[in_width-1:0] = state.irq_mask;
      end
    end
    if (psel && !penable && !idl_is_mapped(paddr)) begin
      next_state.slverr = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state.input_polarity_byte <= idl_pkg::idl_polarity_reset;
      state.output_value_byte <= idl_pkg::idl_output_reset;
      state.irq_status <= idl_pkg::idl_status_reset;
      state.irq_mask <= idl_pkg::idl_mask_reset;
      state.rdata <= idl_pkg::idl_rdata_reset;
      state.slverr <= 1'b0;
      state.irq <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // outputs
  assign prdata = state.rdata;
  assign pslverr = state.slverr & access;
  // open collector: pin pulled low while on, released while off
  assign oc_out = '0;
  assign oc_out_en = state.output_value_byte;
  assign irq = state.irq;
endmodule // idl_port
`default_nettype wire

//--- idl_port_properties.sv
// checker of the isolated i/o port bus answers and output pins
`timescale 1ns/100ps
`default_nettype none
module idl_port_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [6:0] oc_out,
  input wire logic [6:0] oc_out_en
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc, rd, wo, mapped;
  assign acc = psel && penable;
  assign rd = psel && !penable && !pwrite;
  assign wo = acc && pwrite && pstrb[0] && paddr == 12'h004;
  assign mapped = paddr inside {12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h018};
  a_out_update: assert property (wo |=> oc_out_en == $past(pwdata[6:0])) else $error("output lost");
  a_out_hold: assert property (!wo |=> $stable(oc_out_en)) else $error("output moved");
  a_oc_sink: assert property (oc_out == 7'h00) else $error("pin not sinking");
  a_out_readback: assert property (rd && paddr == 12'h004 |=> prdata == 32'($past(oc_out_en))) else $error("rb");
  a_in_width: assert property (rd && paddr == 12'h008 |=> prdata[31:8] == 24'h0) else $error("in upper");
  a_latch_width: assert property (rd && paddr == 12'h00c |=> prdata[31:8] == 24'h0) else $error("latch upper");
  a_clear_reads: assert property (rd && paddr == 12'h010 |=> prdata == 32'h0) else $error("clear reads");
  a_mapped_ok: assert property (acc && mapped |-> pready && !pslverr) else $error("mapped error");
endmodule // idl_port_checker
bind idl_port idl_port_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
  .pready, .pslverr, .oc_out, .oc_out_en);
`default_nettype wire

//--- idl_field_load.sv
// field side of the open-collector outputs: pulled-up load
`timescale 1ns/100ps
`default_nettype none
module idl_field_load (
  input wire logic [6:0] oc_out,
  input wire logic [6:0] oc_out_en,
  output logic [6:0] pin_level
);
  // a released line shows the pull-up, never the last driven level
  assign pin_level = (oc_out_en & oc_out) | ~oc_out_en;
endmodule // idl_field_load
`default_nettype wire

//--- idl_port_test.sv
// self-checking bench of the isolated i/o port
`timescale 1ns/100ps
`default_nettype none
module idl_port_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [7:0] isolated_inputs = 8'hff, p, r;
  logic [6:0] oc_out, oc_out_en, pin_level, o;
  logic [3:0] pstrb = 4'h1;
  logic [32:0] q[$];
  int err_total = 0, samples_checked = 0;
  always #4 pclk = ~pclk;
  idl_port dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .isolated_inputs, .oc_out, .oc_out_en, .irq);
  idl_field_load load (.oc_out, .oc_out_en, .pin_level);
  task automatic stop_test;
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // reads note the expected {pslverr, prdata}; the monitor below compares
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [32:0] e);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      stop_test;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite && q.size() > 0) cmp({pslverr, prdata}, q.pop_front());
  initial begin
    void'($urandom(32'he7ec));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    bus(12'h000, 0, 0, 0);
    bus(12'h004, 0, 0, 0);
    repeat (4) begin
      p = 8'($urandom);
      r = 8'($urandom);
      o = 7'($urandom);
      isolated_inputs <= r;
      bus(12'h000, 1, 32'(p), 0);
      bus(12'h004, 1, 32'(o), 0);
      bus(12'h000, 0, 0, 33'(p));
      bus(12'h008, 0, 0, 33'(8'(~(r ^ p))));
      bus(12'h004, 0, 0, 33'(o));
      cmp(33'(pin_level), 33'(7'(~o)));
    end
    // a write without byte lane 0 must leave the outputs alone
    pstrb <= 4'h0;
    bus(12'h004, 1, 32'(7'(~o)), 0);
    pstrb <= 4'h1;
    bus(12'h004, 0, 0, 33'(o));
    isolated_inputs <= 8'hff;
    bus(12'h000, 1, 0, 0);
    bus(12'h010, 1, 32'hff, 0);
    bus(12'h014, 1, 32'hff, 0);
    bus(12'h00c, 0, 0, 0);
    bus(12'h000, 1, 32'h0f, 0);
    bus(12'h000, 1, 0, 0);
    bus(12'h00c, 0, 0, 33'h0f);
    bus(12'h008, 0, 0, 0);
    bus(12'h010, 1, 32'h05, 0);
    bus(12'h00c, 0, 0, 33'h0a);
    bus(12'h010, 0, 0, 0);
    cmp(33'(irq), 33'h0);
    bus(12'h018, 1, 32'h02, 0);
    repeat (2) @(posedge pclk);
    cmp(33'(irq), 33'h1);
    bus(12'h014, 1, 32'h02, 0);
    repeat (2) @(posedge pclk);
    cmp(33'(irq), 33'h0);
    bus(12'h014, 0, 0, 33'h0d);
    bus(12'h01c, 0, 0, {1'b1, 32'h0});
    stop_test;
  end
endmodule // idl_port_test
`default_nettype wire
